// ===== rtl/fpc_defines.vh
/*
  Constants for the protection command sequencer: bus addresses, command codes,
  operation codes and bus cycle timing in reference clock cycles.
  Assumes a 250 MHz reference clock and an 8-bit bus mode flash.
*/
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH

`define FPC_CLK_MHZ        250
`define FPC_ADDR_W         24
`define FPC_CYC_W          4
`define FPC_ADDR_UNLK1     24'h000aaa
`define FPC_ADDR_UNLK2     24'h000555
`define FPC_ADDR_ZERO      24'h000000
`define FPC_ADDR_PW_HI     24'h000003
`define FPC_D_UNLK1        8'haa
`define FPC_D_UNLK2        8'h55
`define FPC_D_SET_LOCKREG  8'h40
`define FPC_D_SET_PASSWD   8'h60
`define FPC_D_SET_PERSIST  8'hc0
`define FPC_D_SET_LOCKBIT  8'h50
`define FPC_D_SET_TRANS    8'he0
`define FPC_D_SET_EXTBLK   8'h88
`define FPC_D_EXIT1        8'h90
`define FPC_D_EXIT2        8'h00
`define FPC_D_PROG         8'ha0
`define FPC_D_GUARD_SET    8'h00
`define FPC_D_GUARD_CLR    8'h01
`define FPC_D_CLRALL1      8'h80
`define FPC_D_CLRALL2      8'h30
`define FPC_D_UNLOCK1      8'h25
`define FPC_D_UNLOCK2      8'h03
`define FPC_D_UNLOCK_END   8'h29
`define FPC_D_FILLER       8'h00
`define FPC_D_BLANK_PW     8'hff
`define FPC_ST_GUARDED     8'h00
`define FPC_ST_OPEN        8'h01
// Operation codes on i_op.
`define FPC_OP_W           4
`define FPC_OP_ENTER       4'h0
`define FPC_OP_EXIT        4'h1
`define FPC_OP_LOCKREG_WR  4'h2
`define FPC_OP_READ1       4'h3
`define FPC_OP_PW_PROG     4'h4
`define FPC_OP_PW_READ     4'h5
`define FPC_OP_PW_UNLOCK   4'h6
`define FPC_OP_GUARD_SET   4'h7
`define FPC_OP_TGUARD_CLR  4'h8
`define FPC_OP_CLRALL      4'h9
`define FPC_OP_LOCKBIT_SET 4'ha
`define FPC_OP_EXT_PROG    4'hb
`define FPC_OP_EXT_EXIT    4'hc
// Bus cycle phases, in ns and derived cycles (least times round up).
`define FPC_T_SETUP_NS     20
`define FPC_T_PULSE_NS     60
`define FPC_T_HOLD_NS      20
`define FPC_T_UNLOCK_GAP_NS 1000
`define FPC_SETUP_CYC      ((`FPC_T_SETUP_NS * `FPC_CLK_MHZ + 999) / 1000)
`define FPC_PULSE_CYC      ((`FPC_T_PULSE_NS * `FPC_CLK_MHZ + 999) / 1000)
`define FPC_HOLD_CYC       ((`FPC_T_HOLD_NS * `FPC_CLK_MHZ + 999) / 1000)
`define FPC_UNLOCK_GAP_CYC ((`FPC_T_UNLOCK_GAP_NS * `FPC_CLK_MHZ + 999) / 1000)

`endif

// ===== rtl/fpc_bus_cycle.v
/*
  One asynchronous flash bus cycle (write or read) with setup, strobe and hold
  phases counted on the reference clock.
  Assumes the data pins are split into input, output and enable by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.vh"

module fpc_bus_cycle (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_go,
  input  wire        i_rd,
  input  wire [23:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire [7:0]  i_dq_sync,
  output reg         o_done,
  output reg  [7:0]  o_rdata,
  output reg  [23:0] o_addr,
  output reg  [7:0]  o_dq,
  output reg         o_dq_oe,
  output reg         o_ce_n,
  output reg         o_oe_n,
  output reg         o_we_n
);

  localparam [1:0] PH_IDLE  = 2'd0;
  localparam [1:0] PH_SETUP = 2'd1;
  localparam [1:0] PH_PULSE = 2'd2;
  localparam [1:0] PH_HOLD  = 2'd3;
  localparam integer SETUP_I = `FPC_SETUP_CYC;
  localparam integer PULSE_I = `FPC_PULSE_CYC;
  localparam integer HOLD_I  = `FPC_HOLD_CYC;
  localparam [3:0] SETUP_N  = SETUP_I[3:0];
  localparam [3:0] PULSE_N  = PULSE_I[3:0];
  localparam [3:0] HOLD_N   = HOLD_I[3:0];

  reg [1:0] phase;
  reg [3:0] cnt;
  reg       rd;

  // ==========================================================================
  // Cycle sequencer
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase   <= PH_IDLE;
      cnt     <= 4'h0;
      rd      <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= 8'h00;
      o_addr  <= 24'h000000;
      o_dq    <= 8'h00;
      o_dq_oe <= 1'b0;
      o_ce_n  <= 1'b1;
      o_oe_n  <= 1'b1;
      o_we_n  <= 1'b1;
    end else begin
      o_done <= 1'b0;
      case (phase)
        PH_IDLE: begin
          if (i_go) begin
            rd      <= i_rd;
            o_addr  <= i_addr;
            o_dq    <= i_wdata;
            o_dq_oe <= ~i_rd;
            o_ce_n  <= 1'b0;
            cnt     <= SETUP_N;
            phase   <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          if (cnt == 4'h1) begin
            o_we_n <= rd;
            o_oe_n <= ~rd;
            cnt    <= PULSE_N;
            phase  <= PH_PULSE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        PH_PULSE: begin
          if (cnt == 4'h1) begin
            // Data is taken at the end of the strobe, after two sync stages.
            if (rd) begin
              o_rdata <= i_dq_sync;
            end
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            cnt    <= HOLD_N;
            phase  <= PH_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        PH_HOLD: begin
          if (cnt == 4'h1) begin
            o_ce_n  <= 1'b1;
            o_dq_oe <= 1'b0;
            o_done  <= 1'b1;
            phase   <= PH_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== rtl/fpc_controller.v
/*
  Host-side controller for the block protection command sets of a byte-mode
  parallel flash. A user issues one operation at a time; the controller plays
  the matching bus write and read cycles on the flash pins.
  Assumes the flash is asynchronous and its data pins join the dq_* signals.
*/
// Behaviour
// - Exit set: write 90 then 00
// - Always exit before expecting array reads
// - Entry starts AA@AAA, 55@555
// - Lock register: A0, value@00; read one
// - Guard bit: A0, 00 set/01 clear
// - Password program: A0, word@index
// - Unlock: 25,03, four words, 29
// - Lock bit: A0,00; read bit 0
// - Extended block program, read, exit
// - Unlock commands spaced at least 1 us
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.vh"

module fpc_controller (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_req,
  input  wire [3:0]  i_op,
  input  wire [7:0]  i_sel,
  input  wire [23:0] i_addr,
  input  wire [7:0]  i_data,
  input  wire [63:0] i_secret,
  input  wire [7:0]  i_dq_in,
  output reg         o_busy,
  output reg         o_done,
  output reg  [7:0]  o_rdata,
  output reg  [63:0] o_secret_rd,
  output reg         o_status_bit,
  output reg  [23:0] o_addr,
  output reg  [15:0] o_dq_out,
  output reg  [15:0] o_dq_oe,
  output reg         o_ce_n,
  output reg         o_oe_n,
  output reg         o_we_n
);

  localparam [1:0] S_IDLE  = 2'd0;
  localparam [1:0] S_ISSUE = 2'd1;
  localparam [1:0] S_WAIT  = 2'd2;
  localparam [1:0] S_GAP   = 2'd3;
  localparam integer GAP_I = `FPC_UNLOCK_GAP_CYC;
  localparam [8:0] GAP_N   = GAP_I[8:0];

  reg  [1:0]  state;
  reg  [3:0]  op;
  reg  [7:0]  sel;
  reg  [23:0] addr;
  reg  [7:0]  data;
  reg  [63:0] secret;
  reg  [2:0]  step;
  reg  [2:0]  last;
  reg  [8:0]  gap_cnt;
  reg  [7:0]  dq_meta;
  reg  [7:0]  dq_sync;
  reg         go;
  reg         step_rd;
  reg  [23:0] step_addr;
  reg  [7:0]  step_data;
  wire        cyc_done;
  wire [7:0]  cyc_rdata;
  wire [23:0] cyc_addr;
  wire [7:0]  cyc_dq;
  wire        cyc_dq_oe;
  wire        cyc_ce_n;
  wire        cyc_oe_n;
  wire        cyc_we_n;

  // ==========================================================================
  // Input synchroniser for the data pins
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
    end else begin
      dq_meta <= i_dq_in;
      dq_sync <= dq_meta;
    end
  end

  // ==========================================================================
  // Step table: address, data and direction of each bus cycle of an operation
  always @* begin
    step_rd   = 1'b0;
    step_addr = `FPC_ADDR_ZERO;
    step_data = `FPC_D_FILLER;
    last      = 3'd0;
    case (op)
      `FPC_OP_ENTER: begin
        last = 3'd2;
        case (step)
          3'd0: begin
            step_addr = `FPC_ADDR_UNLK1;
            step_data = `FPC_D_UNLK1;
          end
          3'd1: begin
            step_addr = `FPC_ADDR_UNLK2;
            step_data = `FPC_D_UNLK2;
          end
          default: begin
            // Bank bits from the user address ride on the third write.
            step_addr = (addr & 24'hfff000) | `FPC_ADDR_UNLK1;
            step_data = sel;
          end
        endcase
      end
      `FPC_OP_EXIT: begin
        last      = 3'd1;
        step_data = (step == 3'd0) ? `FPC_D_EXIT1 : `FPC_D_EXIT2;
      end
      `FPC_OP_READ1: begin
        step_rd   = 1'b1;
        step_addr = addr;
      end
      `FPC_OP_PW_READ: begin
        last      = 3'd3;
        step_rd   = 1'b1;
        step_addr = {21'h000000, step};
      end
      `FPC_OP_PW_UNLOCK: begin
        last = 3'd6;
        case (step)
          3'd0: step_data = `FPC_D_UNLOCK1;
          3'd1: step_data = `FPC_D_UNLOCK2;
          3'd6: step_data = `FPC_D_UNLOCK_END;
          default: begin
            step_addr = {22'h000000, step[1:0] - 2'd2};
            step_data = secret[(step - 3'd2) * 8 +: 8];
          end
        endcase
      end
      `FPC_OP_CLRALL: begin
        last      = 3'd1;
        step_data = (step == 3'd0) ? `FPC_D_CLRALL1 : `FPC_D_CLRALL2;
      end
      `FPC_OP_EXT_EXIT: begin
        last = 3'd3;
        case (step)
          3'd0: begin
            step_addr = `FPC_ADDR_UNLK1;
            step_data = `FPC_D_UNLK1;
          end
          3'd1: begin
            step_addr = `FPC_ADDR_UNLK2;
            step_data = `FPC_D_UNLK2;
          end
          3'd2: begin
            step_addr = `FPC_ADDR_UNLK1;
            step_data = `FPC_D_EXIT1;
          end
          default: step_data = `FPC_D_EXIT2;
        endcase
      end
      default: begin
        // Two-write program forms: A0 then a payload.
        last = 3'd1;
        if (step == 3'd0) begin
          step_data = `FPC_D_PROG;
        end else begin
          case (op)
            `FPC_OP_LOCKREG_WR:  step_data = data;
            `FPC_OP_PW_PROG: begin
              step_addr = {22'h000000, addr[1:0]};
              step_data = data;
            end
            `FPC_OP_GUARD_SET: begin
              step_addr = addr;
              step_data = `FPC_D_GUARD_SET;
            end
            `FPC_OP_TGUARD_CLR: begin
              step_addr = addr;
              step_data = `FPC_D_GUARD_CLR;
            end
            `FPC_OP_LOCKBIT_SET: step_data = `FPC_D_GUARD_SET;
            `FPC_OP_EXT_PROG: begin
              step_addr = addr;
              step_data = data;
            end
            default: step_data = `FPC_D_FILLER;
          endcase
        end
      end
    endcase
  end

  // ==========================================================================
  // Operation sequencer
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state        <= S_IDLE;
      op           <= `FPC_OP_EXIT;
      sel          <= 8'h00;
      addr         <= 24'h000000;
      data         <= 8'h00;
      secret       <= 64'h0;
      step         <= 3'd0;
      gap_cnt      <= 9'h000;
      go           <= 1'b0;
      o_busy       <= 1'b0;
      o_done       <= 1'b0;
      o_rdata      <= 8'h00;
      o_secret_rd  <= 64'h0;
      o_status_bit <= 1'b0;
    end else begin
      go     <= 1'b0;
      o_done <= 1'b0;
      if (gap_cnt != 9'h000) begin
        gap_cnt <= gap_cnt - 9'h001;
      end
      case (state)
        S_IDLE: begin
          if (i_req) begin
            op     <= i_op;
            sel    <= i_sel;
            addr   <= i_addr;
            data   <= i_data;
            secret <= i_secret;
            step   <= 3'd0;
            o_busy <= 1'b1;
            // A new unlock waits out the spacing of the previous one.
            state  <= (i_op == `FPC_OP_PW_UNLOCK) ? S_GAP : S_ISSUE;
          end
        end
        S_GAP: begin
          if (gap_cnt == 9'h000) begin
            state <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          go    <= 1'b1;
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (step_rd) begin
              o_rdata      <= cyc_rdata;
              o_status_bit <= cyc_rdata[0];
              if (op == `FPC_OP_PW_READ) begin
                o_secret_rd[step[1:0] * 8 +: 8] <= cyc_rdata;
              end
            end
            if (step == last) begin
              if (op == `FPC_OP_PW_UNLOCK) begin
                gap_cnt <= GAP_N;
              end
              o_busy <= 1'b0;
              o_done <= 1'b1;
              state  <= S_IDLE;
            end else begin
              step  <= step + 3'd1;
              state <= S_ISSUE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pin drivers; upper data lines are driven low during command writes.
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_addr   <= 24'h000000;
      o_dq_out <= 16'h0000;
      o_dq_oe  <= 16'h0000;
      o_ce_n   <= 1'b1;
      o_oe_n   <= 1'b1;
      o_we_n   <= 1'b1;
    end else begin
      o_addr   <= cyc_addr;
      o_dq_out <= {8'h00, cyc_dq};
      o_dq_oe  <= {16{cyc_dq_oe}};
      o_ce_n   <= cyc_ce_n;
      o_oe_n   <= cyc_oe_n;
      o_we_n   <= cyc_we_n;
    end
  end

  fpc_bus_cycle u_cycle (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_go      (go),
    .i_rd      (step_rd),
    .i_addr    (step_addr),
    .i_wdata   (step_data),
    .i_dq_sync (dq_sync),
    .o_done    (cyc_done),
    .o_rdata   (cyc_rdata),
    .o_addr    (cyc_addr),
    .o_dq      (cyc_dq),
    .o_dq_oe   (cyc_dq_oe),
    .o_ce_n    (cyc_ce_n),
    .o_oe_n    (cyc_oe_n),
    .o_we_n    (cyc_we_n)
  );

endmodule
`default_nettype wire

// ===== tb/fpc_controller_asserts.sv
/* Pin-level checker for the protection command controller.
   Assumes a bind onto fpc_controller and its single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module fpc_controller_asserts (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_req,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic [23:0] o_addr,
  input wire logic [15:0] o_dq_out,
  input wire logic [15:0] o_dq_oe,
  input wire logic        o_ce_n,
  input wire logic        o_oe_n,
  input wire logic        o_we_n
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ====
  // Strobe shapes
  sequence s_wpulse;
    !o_we_n[*8] ##1 !o_we_n[*7] ##1 o_we_n;
  endsequence
  sequence s_hold;
    !o_ce_n[*4];
  endsequence
  a_strobe_excl: assert property (o_oe_n || o_we_n)
    else $error("strobes overlap");
  a_read_float: assert property (!o_oe_n |-> o_dq_oe == 16'h0000)
    else $error("data driven in read");
  a_upper_zero: assert property (|o_dq_oe |-> &o_dq_oe && o_dq_out[15:8] == 8'h00)
    else $error("upper byte not zero");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done too wide");
  a_accept_busy: assert property (i_req && !o_busy |=> o_busy)
    else $error("request not taken");
  a_done_bound: assert property ($rose(o_busy) |-> ##[1:1000] o_done)
    else $error("no done");
  a_we_width: assert property ($fell(o_we_n) |-> s_wpulse)
    else $error("write strobe width");
  a_we_setup: assert property ($fell(o_we_n) |-> $past(o_ce_n, 4) == 1'b0)
    else $error("write setup short");
  a_we_hold: assert property ($rose(o_we_n) |-> s_hold)
    else $error("write hold short");
  a_bus_stable: assert property (!o_we_n |-> $stable(o_addr) && $stable(o_dq_out))
    else $error("bus moved in strobe");
endmodule

bind fpc_controller fpc_controller_asserts u_chk (
  .i_ref_clk(i_ref_clk),
  .i_rst_n  (i_rst_n),
  .i_req    (i_req),
  .o_busy   (o_busy),
  .o_done   (o_done),
  .o_addr   (o_addr),
  .o_dq_out (o_dq_out),
  .o_dq_oe  (o_dq_oe),
  .o_ce_n   (o_ce_n),
  .o_oe_n   (o_oe_n),
  .o_we_n   (o_we_n)
);
`default_nettype wire

// ===== tb/fpc_flash_model.sv
/* Behavioural byte-mode flash: decodes command writes, answers reads.
   Assumes the bench resolves the data wire and reads the write log. */
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model (
  input  wire logic [23:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  output logic      [7:0]  o_dq
);
  logic [23:0]  wa [0:127];
  logic [7:0]   wd [0:127];
  realtime      wt [0:127];
  logic [7:0]   pw [0:3] = '{default: 8'hff};
  logic [7:0]   ext_word [0:255] = '{default: 8'hff};
  // One guard bit per block; a block is picked by address bits 23:16.
  logic [255:0] persistent_block_guard_bit = '0;
  logic [255:0] transient_block_guard_bit = '0;
  logic [7:0]   lock_reg = 8'hff;
  logic         guard_lock_bit = 1'b1;
  logic [7:0]   mode = 8'h00;
  logic [7:0]   last = 8'h00;
  logic [7:0]   prev;
  logic [7:0]   rv;
  int           wn = 0;
  // ====
  // Write decoding, taken on the trailing edge of the write strobe
  always @(posedge i_we_n) begin
    if (!i_ce_n) begin
      prev = (wn > 0) ? wd[wn-1] : 8'h00;
      wa[wn] = i_addr;
      wd[wn] = i_dq;
      wt[wn] = $realtime;
      if (wn > 1 && wd[wn-2] == 8'haa && prev == 8'h55 && i_addr[11:0] == 12'haaa)
        mode = i_dq;
      else if (prev == 8'h90 && i_dq == 8'h00)
        mode = 8'h00;
      else if (prev == 8'ha0) begin
        case (mode)
          8'h40: lock_reg = i_dq;
          8'h60: pw[i_addr[1:0]] = i_dq;
          8'hc0: if (i_dq == 8'h00) persistent_block_guard_bit[i_addr[23:16]] = 1'b1;
          8'he0: transient_block_guard_bit[i_addr[23:16]] = (i_dq == 8'h00);
          8'h50: if (i_dq == 8'h00) guard_lock_bit = 1'b0;
          8'h88: ext_word[i_addr[7:0]] = i_dq;
          default: ;
        endcase
      end else if (mode == 8'hc0 && prev == 8'h80 && i_dq == 8'h30 && guard_lock_bit)
        persistent_block_guard_bit = '0;
      // Any other write leaves the state alone.
      wn = wn + 1;
    end
  end
  // ====
  // Reads; a released bus shows the inverse so stale data never matches
  always_comb begin
    case (mode)
      8'h40: rv = lock_reg;
      8'h60: rv = pw[i_addr[1:0]];
      8'h50: rv = {7'h00, guard_lock_bit};
      8'h88: rv = ext_word[i_addr[7:0]];
      8'hc0: rv = persistent_block_guard_bit[i_addr[23:16]] ? 8'h00 : 8'h01;
      default: rv = (persistent_block_guard_bit[i_addr[23:16]] ||
                     transient_block_guard_bit[i_addr[23:16]]) ? 8'h00 : 8'h01;
    endcase
  end
  always @(posedge i_oe_n) begin
    last <= rv;
  end
  assign o_dq = (!i_ce_n && !i_oe_n) ? rv : ~last;
endmodule
`default_nettype wire

// ===== tb/fpc_controller_tb.sv
/* Self-checking bench for fpc_controller against a flash model.
   Assumes the design and model files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module fpc_controller_tb;
  logic        i_ref_clk;
  logic        i_rst_n = 1'b0;
  logic        i_req = 1'b0;
  logic [3:0]  i_op = 4'h0;
  logic [7:0]  i_sel = 8'h00;
  logic [23:0] i_addr = 24'h0;
  logic [7:0]  i_data = 8'h00;
  logic [63:0] i_secret = 64'h0;
  wire  [7:0]  m_dq;
  wire  [7:0]  dq_w;
  wire         o_busy, o_done, o_status_bit, o_ce_n, o_oe_n, o_we_n;
  wire  [7:0]  o_rdata;
  wire  [63:0] o_secret_rd;
  wire  [23:0] o_addr;
  wire  [15:0] o_dq_out, o_dq_oe;
  int          err_count = 0;
  int          total_checks = 0;
  int          rp = 0;
  assign dq_w = o_dq_oe[0] ? o_dq_out[7:0] : m_dq;
  fpc_controller dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_op(i_op), .i_sel(i_sel), .i_addr(i_addr), .i_data(i_data), .i_secret(i_secret),
    .i_dq_in(dq_w), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata),
    .o_secret_rd(o_secret_rd), .o_status_bit(o_status_bit), .o_addr(o_addr),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
    .o_we_n(o_we_n));
  fpc_flash_model m (.i_addr(o_addr), .i_dq(dq_w), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n),
    .i_we_n(o_we_n), .o_dq(m_dq));
  // ====
  // Shared tasks
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic op(input logic [3:0] o, input logic [23:0] a, input logic [7:0] d);
    int k;
    @(negedge i_ref_clk);
    for (k = 0; k < 9 && o_busy !== 1'b0; k++)
      @(negedge i_ref_clk);
    i_op = o;
    i_addr = a;
    i_data = d;
    i_req = 1'b1;
    for (k = 0; k < 9 && o_busy !== 1'b1; k++)
      @(negedge i_ref_clk);
    i_req = 1'b0;
    for (k = 0; k < 3000 && o_done !== 1'b1; k++)
      @(negedge i_ref_clk);
    chk("done", o_done, 1'b1);
  endtask
  // A write logged by the model; an all-unknown address means any address.
  task automatic ew(input logic [23:0] a, input logic [7:0] d);
    if (a !== 'x)
      chk("waddr", m.wa[rp], a);
    chk("wdata", m.wd[rp], d);
    rp++;
  endtask
  task automatic enter(input logic [7:0] c, input logic [23:0] a);
    i_sel = c;
    op(4'h0, a, 8'h00);
    rp += 3;
  endtask
  task automatic leave();
    op(4'h1, 24'h0, 8'h00);
    rp += 2;
  endtask
  // ====
  // Scenarios
  task automatic t_sets();
    logic [7:0]  c [6] = '{8'h40, 8'h60, 8'hc0, 8'h50, 8'he0, 8'h88};
    logic [23:0] a;
    foreach (c[i]) begin
      a = (c[i] == 8'hc0 || c[i] == 8'he0) ? 24'h05a000 : 24'h0;
      i_sel = c[i];
      op(4'h0, a, 8'h00);
      ew(24'h000aaa, 8'haa);
      ew(24'h000555, 8'h55);
      ew(a | 24'h000aaa, c[i]);
      chk("set", m.mode, c[i]);
      op(4'h1, 24'hfff000, 8'h00);
      ew('x, 8'h90);
      ew('x, 8'h00);
      chk("set", m.mode, 8'h00);
    end
    $display("t_sets done");
  endtask
  task automatic t_lock();
    enter(8'h40, 24'h0);
    op(4'h2, 24'h0, 8'h3c);
    ew('x, 8'ha0);
    ew(24'h0, 8'h3c);
    op(4'h3, 24'h0, 8'h00);
    chk("rdata", o_rdata, 8'h3c);
    leave();
    $display("t_lock done");
  endtask
  task automatic t_pw();
    logic [31:0] pw = 32'h44332211;
    int          ord [4] = '{3, 0, 2, 1};
    realtime     t = 0;
    enter(8'h60, 24'h0);
    foreach (ord[i]) begin
      op(4'h4, 24'(ord[i]), pw[8*ord[i] +: 8]);
      ew('x, 8'ha0);
      ew(24'(ord[i]), pw[8*ord[i] +: 8]);
    end
    op(4'h5, 24'h0, 8'h00);
    chk("pw", o_secret_rd[31:0], pw);
    chk("writes", m.wn, rp);
    i_secret = {32'h0, pw};
    for (int j = 0; j < 2; j++) begin
      op(4'h6, 24'h0, 8'h00);
      if (j > 0)
        chk("gap", m.wt[rp] - t >= 1000.0, 1'b1);
      ew(24'h0, 8'h25);
      ew(24'h0, 8'h03);
      for (int n = 0; n < 4; n++)
        ew(24'(n), pw[8*n +: 8]);
      ew(24'h0, 8'h29);
      t = m.wt[rp-1];
    end
    leave();
    $display("t_pw done");
  endtask
  task automatic t_guard();
    enter(8'hc0, 24'h010000);
    op(4'h7, 24'h012345, 8'h00);
    ew('x, 8'ha0);
    ew(24'h012345, 8'h00);
    op(4'h3, 24'h012345, 8'h00);
    chk("rdata", o_rdata, 8'h00);
    chk("status", o_status_bit, 1'b0);
    op(4'h3, 24'h002345, 8'h00);
    chk("status", o_status_bit, 1'b1);
    op(4'h8, 24'h002345, 8'h00);
    ew('x, 8'ha0);
    ew(24'h002345, 8'h01);
    op(4'h9, 24'h0, 8'h00);
    ew('x, 8'h80);
    ew(24'h0, 8'h30);
    op(4'h3, 24'h012345, 8'h00);
    chk("status", o_status_bit, 1'b1);
    leave();
    enter(8'h50, 24'h0);
    op(4'ha, 24'h0, 8'h00);
    ew('x, 8'ha0);
    ew('x, 8'h00);
    op(4'h3, 24'h010000, 8'h00);
    chk("status", o_status_bit, 1'b0);
    leave();
    $display("t_guard done");
  endtask
  task automatic t_ext();
    enter(8'h88, 24'h0);
    op(4'hb, 24'h000100, 8'h5c);
    ew('x, 8'ha0);
    ew(24'h000100, 8'h5c);
    op(4'h3, 24'h000100, 8'h00);
    chk("rdata", o_rdata, 8'h5c);
    op(4'hc, 24'h0, 8'h00);
    ew(24'h000aaa, 8'haa);
    ew(24'h000555, 8'h55);
    ew(24'h000aaa, 8'h90);
    ew('x, 8'h00);
    chk("set", m.mode, 8'h00);
    $display("t_ext done");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ====
  // Clock, main sequence and watchdog
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    repeat (20) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    t_sets();
    t_lock();
    t_pw();
    t_guard();
    t_ext();
    results();
  end
  // The whole run needs about 13 us; fifteen times that means a hang.
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
